//--- inc/tptu_pkg.sv
// Package for the three-phase PWM timing unit: register map, field positions, reset values and types.
// Assumes a single 100 MHz core clock and a plain strobe register port.
package tptu_pkg;

	// ******************************************************************
	// Register offsets
	// ******************************************************************
	localparam logic [3:0] OFF_CONTROL    = 4'h0;
	localparam logic [3:0] OFF_STATUS     = 4'h1;
	localparam logic [3:0] OFF_HALF_PER   = 4'h2;
	localparam logic [3:0] OFF_DEAD_TIME  = 4'h3;
	localparam logic [3:0] OFF_DUTY_A     = 4'h4;
	localparam logic [3:0] OFF_DUTY_B     = 4'h5;
	localparam logic [3:0] OFF_DUTY_C     = 4'h6;
	localparam logic [3:0] OFF_OUT_ENABLE = 4'h7;
	localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
	localparam logic [3:0] OFF_IRQ_MASK   = 4'h9;

	// ******************************************************************
	// Field positions and widths
	// ******************************************************************
	localparam int CTRL_DOUBLE_BIT = 2;
	localparam int STAT_HALF_BIT   = 0;
	localparam int STAT_RUN_BIT    = 1;
	localparam int IRQ_SYNC_BIT    = 0;
	localparam int IRQ_BITS        = 1;
	localparam int DEAD_W          = 10;
	localparam int OUT_EN_W        = 9;

	// ******************************************************************
	// Reset values
	// ******************************************************************
	localparam logic [15:0] RST_CONTROL    = 16'h0000;
	localparam logic [15:0] RST_HALF_PER   = 16'h0000;
	localparam logic [9:0]  RST_DEAD_TIME  = 10'h000;
	localparam logic [15:0] RST_DUTY       = 16'h0000;
	localparam logic [8:0]  RST_OUT_ENABLE = 9'h000;

	// ******************************************************************
	// Types
	// ******************************************************************
	// Values latched on each sync edge
	typedef struct packed {
		logic [15:0] half_period;
		logic [9:0]  dead_time;
		logic [15:0] duty_a;
		logic [15:0] duty_b;
		logic [15:0] duty_c;
	} tptu_timing_t;

	// Six active-low gate outputs
	typedef struct packed {
		logic [2:0] high_n;
		logic [2:0] low_n;
	} tptu_gates_t;

	// Timer phase: idle, start-up wait, count up, count down
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FIRST = 2'b01,
		ST_UP    = 2'b10,
		ST_DOWN  = 2'b11
	} tptu_state_t;

endpackage

//--- hw/tptu_timing_unit.sv
// Three-phase centre-based PWM timing unit with register port and sync interrupt.
// Assumes a single-master strobe port on mclk; output control stage lies outside.
// Behaviour
// - Control bit 2 selects double update mode
// - Single mode: one sync, loads timing values
// - Sync edge also latches output enable register
// - Double mode: extra mid-period sync, reloads values
// - Status bit 0 marks second half
// - Three 16-bit duty registers, read/write
// - Gate outputs are active low
// - Dead time moves both edges symmetrically
// - Single mode on-times: twice (duty minus dead)
// - On-times clamp between zero and period
// - Double mode halves use own values
// - Phases B and C match phase A
// - No PWM until period and duties written
// - Half-period write starts the main timer
// - First sync 1.5 half-periods after write
// - Double mode first sync after one half-period
// - Half-period register is 16 bits
// - Ten-bit dead time in two-clock steps; here each step moves each edge by one mclk cycle
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps

module tptu_timing_unit (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 srst,
	// Register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	// Gate outputs, active low
	output tptu_pkg::tptu_gates_t     gates,
	// Period sync pulse and latched output enables
	output logic                      period_sync_pulse,
	output logic      [8:0]           out_enable_latched,
	// Interrupt
	output logic                      irq
);

	// ******************************************************************
	// Software registers
	// ******************************************************************
	logic [15:0]               control_reg;
	logic [15:0]               half_period_reg;
	logic [9:0]                dead_time_reg;
	logic [15:0]               duty_reg [3];
	logic [8:0]                out_enable_reg;
	logic [3:0]                written_reg;
	logic [0:0]                irq_status_reg;
	logic [0:0]                irq_mask_reg;
	tptu_pkg::tptu_timing_t    act_reg;
	tptu_pkg::tptu_state_t     state_reg;
	tptu_pkg::tptu_state_t     state_next;
	logic [16:0]               cnt_reg;
	logic [16:0]               cnt_next;
	logic                      half_reg;
	logic                      sync_reg;
	logic [15:0]               rdata_next;

	// Decodes of the write strobe
	wire wr_ctrl = reg_wr && (reg_addr == tptu_pkg::OFF_CONTROL);
	wire wr_half = reg_wr && (reg_addr == tptu_pkg::OFF_HALF_PER);
	wire wr_dead = reg_wr && (reg_addr == tptu_pkg::OFF_DEAD_TIME);
	wire wr_da   = reg_wr && (reg_addr == tptu_pkg::OFF_DUTY_A);
	wire wr_db   = reg_wr && (reg_addr == tptu_pkg::OFF_DUTY_B);
	wire wr_dc   = reg_wr && (reg_addr == tptu_pkg::OFF_DUTY_C);
	wire wr_oen  = reg_wr && (reg_addr == tptu_pkg::OFF_OUT_ENABLE);
	wire wr_ist  = reg_wr && (reg_addr == tptu_pkg::OFF_IRQ_STATUS);
	wire wr_imsk = reg_wr && (reg_addr == tptu_pkg::OFF_IRQ_MASK);

	wire double_mode = control_reg[tptu_pkg::CTRL_DOUBLE_BIT];
	wire all_written = &written_reg;
	wire running     = (state_reg == tptu_pkg::ST_UP) || (state_reg == tptu_pkg::ST_DOWN);

	// Snapshot of current software values, taken on every sync edge
	tptu_pkg::tptu_timing_t shadow;
	assign shadow = '{half_period: half_period_reg, dead_time: dead_time_reg,
	                  duty_a: duty_reg[0], duty_b: duty_reg[1], duty_c: duty_reg[2]};

	// ******************************************************************
	// Register writes
	// ******************************************************************
	// Configuration storage
	always_ff @(posedge mclk) begin
		if (srst) begin
			control_reg     <= tptu_pkg::RST_CONTROL;
			half_period_reg <= tptu_pkg::RST_HALF_PER;
			dead_time_reg   <= tptu_pkg::RST_DEAD_TIME;
			out_enable_reg  <= tptu_pkg::RST_OUT_ENABLE;
			irq_mask_reg    <= '0;
			for (int i = 0; i < 3; i++) begin
				duty_reg[i] <= tptu_pkg::RST_DUTY;
			end
		end else begin
			if (wr_ctrl) control_reg <= reg_wdata;
			if (wr_half) half_period_reg <= reg_wdata;
			if (wr_dead) dead_time_reg <= reg_wdata[9:0];
			if (wr_da) duty_reg[0] <= reg_wdata;
			if (wr_db) duty_reg[1] <= reg_wdata;
			if (wr_dc) duty_reg[2] <= reg_wdata;
			if (wr_oen) out_enable_reg <= reg_wdata[8:0];
			if (wr_imsk) irq_mask_reg <= reg_wdata[0:0];
		end
	end

	// Written-once flags; cleared only by reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			written_reg <= 4'h0;
		end else begin
			written_reg <= written_reg | {wr_dc, wr_db, wr_da, wr_half};
		end
	end

	// ******************************************************************
	// Main timer
	// ******************************************************************
	// Start-up waits one half period (double) or 1.5 (single) after the period
	// write, then the counter runs 0..hp-1 up and hp-1..0 down; the bottom turn-around
	// is a sync edge, the top one only in double mode. Both halves see the same count values, so on-times stay even.
	wire [16:0] hp17       = {1'b0, act_reg.half_period};
	wire [16:0] hp_cur17   = {1'b0, half_period_reg};
	wire [16:0] first_goal = double_mode ? hp_cur17 : (hp_cur17 + {2'b00, half_period_reg[15:1]});
	wire        first_done = (cnt_reg + 17'h00001 >= first_goal) && all_written;
	wire        mid_edge   = (state_reg == tptu_pkg::ST_UP) && (cnt_reg + 17'h00001 >= hp17);
	wire        end_edge   = (state_reg == tptu_pkg::ST_DOWN) && (cnt_reg == 17'h00000);
	wire        start_edge = ((state_reg == tptu_pkg::ST_FIRST) && first_done) || end_edge;
	wire        sync_now   = start_edge || (mid_edge && double_mode);

	// Next state of the timer
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			tptu_pkg::ST_IDLE: begin
				if (wr_half) begin
					state_next = tptu_pkg::ST_FIRST;
					cnt_next   = 17'h00000;
				end
			end
			tptu_pkg::ST_FIRST: begin
				cnt_next = cnt_reg + 17'h00001;
				if (first_done) begin
					state_next = tptu_pkg::ST_UP;
					cnt_next   = 17'h00000;
				end
			end
			tptu_pkg::ST_UP: begin
				cnt_next = cnt_reg + 17'h00001;
				if (mid_edge) begin
					state_next = tptu_pkg::ST_DOWN;
					cnt_next   = (double_mode ? hp_cur17 : hp17) - 17'h00001;
				end
			end
			tptu_pkg::ST_DOWN: begin
				cnt_next = cnt_reg - 17'h00001;
				if (end_edge) begin
					state_next = tptu_pkg::ST_UP;
					cnt_next   = 17'h00000;
				end
			end
			default: begin
				state_next = tptu_pkg::ST_IDLE;
				cnt_next   = 17'h00000;
			end
		endcase
	end

	// Timer state and latched timing set
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= tptu_pkg::ST_IDLE;
			cnt_reg   <= 17'h00000;
			act_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (sync_now) act_reg <= shadow;
		end
	end

	// Sync pulse, half flag and enable latch; one cycle per sync edge
	always_ff @(posedge mclk) begin
		if (srst) begin
			sync_reg           <= 1'b0;
			half_reg           <= 1'b0;
			out_enable_latched <= tptu_pkg::RST_OUT_ENABLE;
		end else begin
			sync_reg <= sync_now;
			if (start_edge) half_reg <= 1'b0;
			else if (mid_edge) half_reg <= 1'b1;
			if (sync_now) out_enable_latched <= out_enable_reg;
		end
	end
	assign period_sync_pulse = sync_reg;

	// ******************************************************************
	// Compare and dead time
	// ******************************************************************
	// Up/down count makes compares symmetric, so a single threshold per side
	// moves both edges by the dead time: high on while cnt < duty-dead,
	// low on while cnt >= duty+dead. Clamping falls out of the compares.
	function automatic logic [1:0] phase_gates(input logic [16:0] cnt, input logic [15:0] duty,
	                                            input logic [9:0] dead);
		logic [17:0] hi_th;
		logic [17:0] lo_th;
		hi_th = {2'b00, duty} - {8'h00, dead};
		lo_th = {2'b00, duty} + {8'h00, dead};
		phase_gates[1] = !(hi_th[17] == 1'b0 && {1'b0, cnt} < hi_th);
		phase_gates[0] = !({1'b0, cnt} >= lo_th);
	endfunction

	logic [1:0] pg [3];
	assign pg[0] = phase_gates(cnt_reg, act_reg.duty_a, act_reg.dead_time);
	assign pg[1] = phase_gates(cnt_reg, act_reg.duty_b, act_reg.dead_time);
	assign pg[2] = phase_gates(cnt_reg, act_reg.duty_c, act_reg.dead_time);

	// Registered gates; off (high) until the timer runs
	always_ff @(posedge mclk) begin
		if (srst) begin
			gates <= '1;
		end else begin
			for (int i = 0; i < 3; i++) begin
				gates.high_n[i] <= running ? pg[i][1] : 1'b1;
				gates.low_n[i]  <= running ? pg[i][0] : 1'b1;
			end
		end
	end

	// ******************************************************************
	// Interrupt and read-back
	// ******************************************************************
	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~(wr_ist ? reg_wdata[0:0] : 1'b0)) | sync_now;
		end
	end
	assign irq = |(irq_status_reg & irq_mask_reg);

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			tptu_pkg::OFF_CONTROL:    rdata_next = control_reg;
			tptu_pkg::OFF_STATUS:     rdata_next = {14'h0000, running, half_reg};
			tptu_pkg::OFF_HALF_PER:   rdata_next = half_period_reg;
			tptu_pkg::OFF_DEAD_TIME:  rdata_next = {6'h00, dead_time_reg};
			tptu_pkg::OFF_DUTY_A:     rdata_next = duty_reg[0];
			tptu_pkg::OFF_DUTY_B:     rdata_next = duty_reg[1];
			tptu_pkg::OFF_DUTY_C:     rdata_next = duty_reg[2];
			tptu_pkg::OFF_OUT_ENABLE: rdata_next = {7'h00, out_enable_reg};
			tptu_pkg::OFF_IRQ_STATUS: rdata_next = {15'h0000, irq_status_reg};
			tptu_pkg::OFF_IRQ_MASK:   rdata_next = {15'h0000, irq_mask_reg};
			default:                  rdata_next = 16'h0000;
		endcase
	end

	// Read data valid the cycle after the strobe only
	always_ff @(posedge mclk) begin
		if (srst) reg_rdata <= 16'h0000;
		else reg_rdata <= reg_rd ? rdata_next : 16'h0000;
	end

	// ******************************************************************
	// Checks
	// ******************************************************************
	sequence s_sync_edge;
		sync_now ##1 period_sync_pulse;
	endsequence

	chk_mode_reset: assert property (@(posedge mclk) srst |=> !double_mode)
		else $error("mode not single after reset");
	chk_sync_pulse: assert property (@(posedge mclk) disable iff (srst) sync_now |-> s_sync_edge)
		else $error("sync pulse missing");
	chk_enable_latch: assert property (@(posedge mclk) disable iff (srst)
		sync_now |=> out_enable_latched == $past(out_enable_reg))
		else $error("enable not latched on sync");
	chk_mid_sync: assert property (@(posedge mclk) disable iff (srst)
		(mid_edge && double_mode) |=> period_sync_pulse)
		else $error("midpoint sync missing");
	chk_no_mid_single: assert property (@(posedge mclk) disable iff (srst)
		(mid_edge && !double_mode && !start_edge) |=> !period_sync_pulse)
		else $error("extra sync in single mode");
	chk_half_flag: assert property (@(posedge mclk) disable iff (srst)
		mid_edge && !start_edge |=> half_reg ##0 state_reg == tptu_pkg::ST_DOWN)
		else $error("half flag wrong");
	chk_gates_idle: assert property (@(posedge mclk) disable iff (srst)
		!all_written |=> gates == '1)
		else $error("gates active before init");
	chk_no_shoot: assert property (@(posedge mclk) disable iff (srst)
		!(gates.high_n[0] == 1'b0 && gates.low_n[0] == 1'b0))
		else $error("both phase A switches on");
	chk_timer_start: assert property (@(posedge mclk) disable iff (srst)
		(wr_half && state_reg == tptu_pkg::ST_IDLE) |=> state_reg == tptu_pkg::ST_FIRST)
		else $error("timer not started");
	chk_irq_sticky: assert property (@(posedge mclk) disable iff (srst)
		sync_now |=> irq_status_reg[0])
		else $error("sync event lost");
	chk_duty_write: assert property (@(posedge mclk) disable iff (srst)
		wr_db |=> duty_reg[1] == $past(reg_wdata))
		else $error("duty write lost");

	// Turn-around steps of the up/down counter
	sequence s_top_turn;
		state_reg == tptu_pkg::ST_DOWN && cnt_reg == hp17 - 17'h00001;
	endsequence

	sequence s_bottom_turn;
		state_reg == tptu_pkg::ST_UP && cnt_reg == 17'h00000 && !half_reg;
	endsequence

	// Register port and latching
	chk_mode_write: assert property (@(posedge mclk) disable iff (srst)
		wr_ctrl |=> double_mode == $past(reg_wdata[tptu_pkg::CTRL_DOUBLE_BIT]))
		else $error("mode bit not stored");
	chk_act_load: assert property (@(posedge mclk) disable iff (srst)
		sync_now |=> act_reg == $past(shadow))
		else $error("timing set not loaded on sync");
	chk_act_hold: assert property (@(posedge mclk) disable iff (srst)
		!sync_now |=> $stable(act_reg))
		else $error("timing set changed between syncs");
	chk_oe_hold: assert property (@(posedge mclk) disable iff (srst)
		!sync_now |=> $stable(out_enable_latched))
		else $error("enable copy changed between syncs");
	chk_half_clear: assert property (@(posedge mclk) disable iff (srst)
		start_edge |=> !half_reg)
		else $error("half flag not cleared at period start");
	chk_status_read: assert property (@(posedge mclk) disable iff (srst)
		(reg_rd && reg_addr == tptu_pkg::OFF_STATUS) |=> reg_rdata[0] == $past(half_reg))
		else $error("status half bit misread");
	chk_duty_read: assert property (@(posedge mclk) disable iff (srst)
		(reg_rd && reg_addr == tptu_pkg::OFF_DUTY_C) |=> reg_rdata == $past(duty_reg[2]))
		else $error("duty read wrong");
	chk_dead_write: assert property (@(posedge mclk) disable iff (srst)
		wr_dead |=> dead_time_reg == $past(reg_wdata[9:0]))
		else $error("dead time write lost");
	chk_half_write: assert property (@(posedge mclk) disable iff (srst)
		wr_half |=> half_period_reg == $past(reg_wdata))
		else $error("half period write lost");

	// Gate safety and start-up gating
	chk_gates_stopped: assert property (@(posedge mclk) disable iff (srst)
		!running |=> gates == '1)
		else $error("gates active while timer stopped");
	chk_no_shoot_b: assert property (@(posedge mclk) disable iff (srst)
		!(gates.high_n[1] == 1'b0 && gates.low_n[1] == 1'b0))
		else $error("both phase B switches on");
	chk_no_shoot_c: assert property (@(posedge mclk) disable iff (srst)
		!(gates.high_n[2] == 1'b0 && gates.low_n[2] == 1'b0))
		else $error("both phase C switches on");
	chk_written_hold: assert property (@(posedge mclk) disable iff (srst)
		all_written |=> all_written)
		else $error("written flags lost");
	chk_timer_wait: assert property (@(posedge mclk) disable iff (srst)
		(state_reg == tptu_pkg::ST_FIRST && !first_done) |=> state_reg == tptu_pkg::ST_FIRST)
		else $error("timer left start-up early");
	chk_first_turn: assert property (@(posedge mclk) disable iff (srst)
		(state_reg == tptu_pkg::ST_FIRST && first_done) |=> s_bottom_turn)
		else $error("first period not started from zero");

	// Counter shape and sync status clear
	chk_top_turn: assert property (@(posedge mclk) disable iff (srst)
		mid_edge |=> s_top_turn)
		else $error("counter did not turn at top");
	chk_bottom_turn: assert property (@(posedge mclk) disable iff (srst)
		end_edge |=> s_bottom_turn)
		else $error("counter did not turn at bottom");
	chk_count_range: assert property (@(posedge mclk) disable iff (srst)
		running |-> cnt_reg < hp17)
		else $error("count beyond half period");
	chk_irq_clear: assert property (@(posedge mclk) disable iff (srst)
		(wr_ist && reg_wdata[0] && !sync_now) |=> !irq_status_reg[0])
		else $error("sync status not cleared");

endmodule

//--- testbench/tptu_gate_model.sv
// Gate driver model: counts the on-cycles of every switch between two period sync pulses.
// Assumes active-low gate commands and a one-cycle sync pulse, both on mclk.
`timescale 1ns/1ps

module tptu_gate_model (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  srst,
	// From the timing unit
	input  wire tptu_pkg::tptu_gates_t gates,
	input  wire logic                  period_sync_pulse,
	// Counts over the last complete sync interval; overlap counts since reset
	output int                         hi_on[3],
	output int                         lo_on[3],
	output int                         span,
	output int                         overlap
);
	int hi_acc[3];
	int lo_acc[3];
	int span_acc;
	logic sync_d;

	// A low level turns a switch on; both on at once would short the link.
	// Gates trail the sync pulse by one clock, so the window opens a clock later.
	always @(posedge mclk) begin
		if (srst) begin
			overlap <= 0;
			span_acc <= 0;
			sync_d <= 1'b0;
		end else begin
			sync_d <= period_sync_pulse;
			span_acc <= sync_d ? 1 : span_acc + 1;
			if (sync_d) begin
				span <= span_acc;
			end
			for (int i = 0; i < 3; i++) begin
				hi_on[i] <= sync_d ? hi_acc[i] : hi_on[i];
				lo_on[i] <= sync_d ? lo_acc[i] : lo_on[i];
				hi_acc[i] <= (sync_d ? 0 : hi_acc[i]) + (gates.high_n[i] ? 0 : 1);
				lo_acc[i] <= (sync_d ? 0 : lo_acc[i]) + (gates.low_n[i] ? 0 : 1);
				if (!gates.high_n[i] && !gates.low_n[i]) begin
					overlap <= overlap + 1;
				end
			end
		end
	end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the three-phase PWM timing unit.
// Assumes the gate driver model beside it and a 100 MHz core clock.
`timescale 1ns/1ps

module tb;
	logic                  mclk;
	logic                  srst;
	logic [3:0]            reg_addr;
	logic [15:0]           reg_wdata;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [15:0]           reg_rdata;
	tptu_pkg::tptu_gates_t gates;
	logic                  period_sync_pulse;
	logic [8:0]            out_enable_latched;
	logic                  irq;
	int                    hi_on[3];
	int                    lo_on[3];
	int                    span;
	int                    overlap;
	int                    n_errors;
	int                    checked;
	int                    hp;
	int                    dt;
	int                    n;
	int                    du[3];
	logic [15:0]           d;
	logic [8:0]            oe;
	logic                  half_seen;

	// ******************************************************************
	// Design and gate driver model
	// ******************************************************************
	tptu_timing_unit uut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gates(gates),
		.period_sync_pulse(period_sync_pulse), .out_enable_latched(out_enable_latched), .irq(irq));
	tptu_gate_model drv (.mclk(mclk), .srst(srst), .gates(gates), .period_sync_pulse(period_sync_pulse),
		.hi_on(hi_on), .lo_on(lo_on), .span(span), .overlap(overlap));

	// 100 MHz core clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ******************************************************************
	// Helpers
	// ******************************************************************
	// Expected on-times over a full period, clamped to zero and the period
	function automatic int hi_exp(int du1, int t, int h);
		int v = 2 * (du1 - t);
		return v < 0 ? 0 : (v > 2 * h ? 2 * h : v);
	endfunction

	function automatic int lo_exp(int du1, int t, int h);
		int v = 2 * (h - du1 - t);
		return v < 0 ? 0 : (v > 2 * h ? 2 * h : v);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Strobes start one edge after entry, so back-to-back calls never drive a strobe twice at once
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] v;
		rd(a, v);
		check(v, exp);
	endtask

	// Bounded wait; returns the edges passed until the pulse is seen
	task automatic wait_sync(output int cnt);
		cnt = 0;
		do begin
			@(posedge mclk);
			#1 cnt++;
		end while (period_sync_pulse !== 1'b1 && cnt < 5000);
	endtask

	// Half period goes before the duties so start-up timing is defined
	task automatic setup(input bit first);
		wr(tptu_pkg::OFF_DEAD_TIME, 16'(dt));
		wr(tptu_pkg::OFF_HALF_PER, 16'(hp));
		wr(tptu_pkg::OFF_DUTY_A, 16'(du[0]));
		wr(tptu_pkg::OFF_DUTY_B, 16'(du[1]));
		if (first) check(gates, 6'h3F);
		wr(tptu_pkg::OFF_DUTY_C, 16'(du[2]));
	endtask

	task automatic final_report;
		$display("Mismatches %0d, comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog sized well above the whole sequence
	initial begin
		#(600000);
		n_errors++;
		final_report();
	end

	// ******************************************************************
	// Main sequence
	// ******************************************************************
	initial begin
		srst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_errors = 0;
		checked = 0;
		void'($urandom(32'h0da677d9));
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		#1 check(gates, 6'h3F);
		rchk(tptu_pkg::OFF_CONTROL, 16'h0000);
		d = 16'($urandom);
		wr(tptu_pkg::OFF_DUTY_B, d);
		rchk(tptu_pkg::OFF_DUTY_B, d);
		wr(tptu_pkg::OFF_DEAD_TIME, 16'hFFFF);
		rchk(tptu_pkg::OFF_DEAD_TIME, 16'h03FF);
		rchk(4'hF, 16'h0000);
		wr(tptu_pkg::OFF_IRQ_MASK, 16'h0001);
		// Start-up timing and the sync interrupt
		hp = 24;
		dt = 2;
		du = '{10, 12, 14};
		setup(1'b1);
		wait_sync(n);
		check(n + 6 >= 35 && n + 6 <= 40, 1'b1);
		check(irq, 1'b1);
		wr(tptu_pkg::OFF_IRQ_STATUS, 16'h0001);
		check(irq, 1'b0);
		wr(tptu_pkg::OFF_IRQ_MASK, 16'h0000);
		wait_sync(n);
		check(irq, 1'b0);
		rchk(tptu_pkg::OFF_IRQ_STATUS, 16'h0001);
		// Random settings with corner duties, single update mode
		for (int k = 0; k < 6; k++) begin
			hp = 20 + $urandom % 30;
			dt = $urandom % 4;
			foreach (du[i]) du[i] = $urandom % (hp + 1);
			if (k == 0) du[0] = 0;
			if (k == 1) du[1] = hp;
			if (k == 2) du[2] = dt;
			oe = 9'($urandom);
			wait_sync(n);
			setup(1'b0);
			wr(tptu_pkg::OFF_OUT_ENABLE, {7'h00, oe});
			wait_sync(n);
			check(out_enable_latched, oe);
			wait_sync(n);
			check(n, 2 * hp);
			rd(tptu_pkg::OFF_STATUS, d);
			check(d[0], 1'b0);
			repeat (hp) @(posedge mclk);
			rd(tptu_pkg::OFF_STATUS, d);
			check(d[0], 1'b1);
			foreach (du[i]) begin
				check(hi_on[i], hi_exp(du[i], dt, hp));
				check(lo_on[i], lo_exp(du[i], dt, hp));
			end
			check(span, 2 * hp);
		end
		// Double update mode: a sync every half period
		wr(tptu_pkg::OFF_CONTROL, 16'h0004);
		rchk(tptu_pkg::OFF_CONTROL, 16'h0004);
		wait_sync(n);
		wait_sync(n);
		check(n, hp);
		rd(tptu_pkg::OFF_STATUS, d);
		half_seen = d[0];
		wait_sync(n);
		rd(tptu_pkg::OFF_STATUS, d);
		check(d[0], !half_seen);
		check(hi_on[0] + hi_on[0], hi_exp(du[0], dt, hp));
		check(lo_on[0] + lo_on[0], lo_exp(du[0], dt, hp));
		check(overlap, 0);
		// Reset in mid-run, then double-mode start-up
		@(posedge mclk);
		srst <= 1'b1;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		#1 check(gates, 6'h3F);
		wr(tptu_pkg::OFF_CONTROL, 16'h0004);
		hp = 30;
		setup(1'b1);
		wait_sync(n);
		check(n + 6 >= 29 && n + 6 <= 34, 1'b1);
		final_report();
	end
endmodule
